// ### shared/bsc_pkg.sv
// Package for the breaker status and control block: register map, fields, timing constants.
package bsc_pkg;
   // Register word indices on the plain register port.
   localparam logic [3:0] ADDR_CTRL0   = 4'h0;
   localparam logic [3:0] ADDR_CTRL1   = 4'h1;
   localparam logic [3:0] ADDR_ALMDLY0 = 4'h2;
   localparam logic [3:0] ADDR_ALMDLY1 = 4'h3;
   localparam logic [3:0] ADDR_MCHOLD0 = 4'h4;
   localparam logic [3:0] ADDR_MCHOLD1 = 4'h5;
   localparam logic [3:0] ADDR_STATUS0 = 4'h6;
   localparam logic [3:0] ADDR_STATUS1 = 4'h7;
   localparam logic [3:0] ADDR_IRQST   = 4'h8;
   localparam logic [3:0] ADDR_IRQMSK  = 4'h9;
   // Control word fields.
   localparam int CTRL_FUNC_EN = 0;
   localparam int CTRL_PB_EN   = 1;
   localparam int CTRL_INDEP   = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   // Status word fields.
   localparam int ST_CLOSED   = 0;
   localparam int ST_POLES    = 1;
   localparam int ST_DISAGREE = 4;
   localparam int ST_ALARM    = 5;
   localparam int ST_OOS      = 6;
   localparam int ST_LOCAL    = 7;
   localparam int ST_MCHOLD   = 8;
   localparam int ST_OPEN_OUT = 9;
   localparam int ST_CLS_OUT  = 10;
   // Interrupt status fields, per breaker b at offset 4*b.
   localparam int IRQ_DISAGREE = 0;
   localparam int IRQ_ALARM    = 1;
   localparam int IRQ_POSCHG   = 2;
   localparam int IRQ_MCEND    = 3;
   // Timing: delays are set in 1 ms steps.
   localparam int CLK_HZ      = 25000000;
   localparam int STEP_US     = 1000;
   localparam int STEP_CYCLES = (CLK_HZ / 1000000) * STEP_US;
   localparam int TICK_W      = 15;
   localparam logic [31:0] DELAY_RESET = 32'h0;
endpackage : bsc_pkg

// ### verilog/bsc_breaker_ctrl.sv
// Two-instance breaker control and pole position tracking with register port and interrupt.
// Function
// - Control features of an instance act only while its function setting is enabled.
// - Push-button open and close act only when push-button control is enabled.
// - Ganged mode: all poles together, position from phase-A/gang input alone.
// - Independent mode: phase A, B and C tracked from their own inputs.
// - Ganged mode ignores phase-B and phase-C position inputs entirely.
// - Disagreement is reported only after inputs differ for the alarm delay; here it may come up to one 1 ms step early.
// - Open output follows the selected open command while enabled.
// - Close output follows the selected close command while enabled.
// - Manual close keeps setting changes in force for the hold interval; here the hold may end up to one 1 ms step early.
// - External alarm state comes from the selected alarm input.
// - Breaker is out of service while the out-of-service input is set.
// - Two identical instances; a single breaker uses the first.
// - Local-control status is reported from the selected source input.
//
// The address map and the address-and-strobe port were left to the implementer.
module bsc_breaker_ctrl #(
   parameter int NBKR = 2
) (
   // Clock and reset.
   input  wire  logic                clk,
   input  wire  logic                rst,
   // Register port.
   input  wire  logic [3:0]          reg_addr,
   input  wire  logic [31:0]         reg_wdata,
   input  wire  logic                reg_wr,
   input  wire  logic                reg_rd,
   output logic       [31:0]         reg_rdata,
   // Per-breaker operands, index 0 is the first breaker.
   input  wire  logic [NBKR-1:0]     open_cmd,
   input  wire  logic [NBKR-1:0]     close_cmd,
   input  wire  logic [NBKR-1:0]     pb_open,
   input  wire  logic [NBKR-1:0]     pb_close,
   input  wire  logic [NBKR-1:0]     manual_close,
   input  wire  logic [NBKR-1:0]     pos_a_gang,
   input  wire  logic [NBKR-1:0]     pos_b,
   input  wire  logic [NBKR-1:0]     pos_c,
   input  wire  logic [NBKR-1:0]     external_breaker_alarm_input,
   input  wire  logic [NBKR-1:0]     breaker_out_of_service_input,
   input  wire  logic [NBKR-1:0]     local_control_status_source,
   // Per-breaker outputs.
   output logic       [NBKR-1:0]     bkr_open_out,
   output logic       [NBKR-1:0]     bkr_close_out,
   output logic       [3*NBKR-1:0]   pole_closed,
   output logic       [NBKR-1:0]     bkr_closed,
   output logic       [NBKR-1:0]     pole_disagree,
   output logic       [NBKR-1:0]     bkr_alarm,
   output logic       [NBKR-1:0]     bkr_out_of_service,
   output logic       [NBKR-1:0]     bkr_local,
   output logic       [NBKR-1:0]     manual_close_hold,
   // Interrupt.
   output logic                      irq
);

   // Register words, one word per breaker for each setting and status apart from the shared interrupt words, with breaker 1 first.
   // Words 0 and 1 hold the control bits: function, push button and independent-pole mode.
   // Words 2 and 3 hold the pole disagreement delay in 1 ms steps.
   // Words 4 and 5 hold the manual close hold interval in 1 ms steps.
   // Words 6 and 7 show position, poles, disagreement, indications and outputs.
   // Word 8 is the interrupt status, four events per breaker, cleared by a read.
   // Word 9 is the interrupt mask with the layout of the interrupt status.
   // Unmapped words read as zero and ignore writes.

   localparam logic [bsc_pkg::TICK_W-1:0] TICK_LAST =
      bsc_pkg::TICK_W'(bsc_pkg::STEP_CYCLES - 1);

   logic [bsc_pkg::TICK_W-1:0] tick_cnt_r;
   logic                       tick;
   logic [2:0]                 ctrl_r      [NBKR];
   logic [31:0]                alarm_dly_r [NBKR];
   logic [31:0]                mc_hold_r   [NBKR];
   logic [31:0]                dis_cnt_r   [NBKR];
   logic [31:0]                mc_cnt_r    [NBKR];
   logic [NBKR-1:0]            dis_r;
   logic [NBKR-1:0]            mc_r;
   logic [NBKR-1:0]            closed_prev_r;
   logic [NBKR-1:0]            alarm_prev_r;
   logic [NBKR-1:0]            dis_prev_r;
   logic [4*NBKR-1:0]          irq_st_r;
   logic [4*NBKR-1:0]          irq_msk_r;
   logic [4*NBKR-1:0]          irq_set;
   logic [NBKR-1:0]            en;
   logic [NBKR-1:0]            disagree_now;
   logic [NBKR-1:0]            mc_end;
   logic [4*NBKR-1:0]          irq_st_nxt;
   logic                       irq_rd_clr;
   logic                       msk_wr;
   logic [31:0]                rd_word;

   // One-cycle enable pulse per 1 ms step. Both timers share this free-running step, so an
   // interval may end up to one step early against the moment it was started.
   assign tick = (tick_cnt_r == TICK_LAST);

   always_ff @(posedge clk) begin
      if (rst || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end

   // Status word of one breaker.
   function automatic logic [31:0] status_word(input int b);
      logic [31:0] w;
      w = '0;
      w[bsc_pkg::ST_CLOSED]           = bkr_closed[b];
      w[bsc_pkg::ST_POLES +: 3]       = pole_closed[3*b +: 3];
      w[bsc_pkg::ST_DISAGREE]         = pole_disagree[b];
      w[bsc_pkg::ST_ALARM]            = bkr_alarm[b];
      w[bsc_pkg::ST_OOS]              = bkr_out_of_service[b];
      w[bsc_pkg::ST_LOCAL]            = bkr_local[b];
      w[bsc_pkg::ST_MCHOLD]           = manual_close_hold[b];
      w[bsc_pkg::ST_OPEN_OUT]         = bkr_open_out[b];
      w[bsc_pkg::ST_CLS_OUT]          = bkr_close_out[b];
      return w;
   endfunction

   // True when the port addresses word b of a bank of per-breaker words.
   function automatic logic word_hit(input logic [3:0] addr, input logic [3:0] base,
                                     input int b);
      logic [3:0] a;
      a = base + 4'(b);
      return addr == a;
   endfunction

   // True while the tracked poles are neither all open nor all closed.
   function automatic logic poles_differ(input logic pa, input logic pb, input logic pc);
      logic all_closed;
      logic all_open;
      all_closed = pa & pb & pc;
      all_open   = ~(pa | pb | pc);
      return !(all_closed || all_open);
   endfunction

   // Register word returned for a read of the given index.
   function automatic logic [31:0] read_word(input logic [3:0] addr);
      logic [31:0] w;
      w = '0;
      unique case (addr)
         bsc_pkg::ADDR_CTRL0:   w = {29'h0, ctrl_r[0]};
         bsc_pkg::ADDR_CTRL1:   w = {29'h0, ctrl_r[NBKR-1]};
         bsc_pkg::ADDR_ALMDLY0: w = alarm_dly_r[0];
         bsc_pkg::ADDR_ALMDLY1: w = alarm_dly_r[NBKR-1];
         bsc_pkg::ADDR_MCHOLD0: w = mc_hold_r[0];
         bsc_pkg::ADDR_MCHOLD1: w = mc_hold_r[NBKR-1];
         bsc_pkg::ADDR_STATUS0: w = status_word(0);
         bsc_pkg::ADDR_STATUS1: w = status_word(NBKR-1);
         bsc_pkg::ADDR_IRQST:   w = 32'(irq_st_r);
         bsc_pkg::ADDR_IRQMSK:  w = 32'(irq_msk_r);
         default:               w = 32'h0;
      endcase
      return w;
   endfunction

   // Each breaker gets its own copy of the logic below; breaker 1 is index 0.
   genvar g;
   generate
      for (g = 0; g < NBKR; g++) begin : g_bkr
         // Per-breaker position, command and event nets.
         logic pa;
         logic pb;
         logic pc;
         logic indep;
         logic pb_ok;
         logic open_nxt;
         logic close_nxt;
         logic dis_due;
         logic mc_step;
         logic ev_dis_rise;
         logic ev_alarm_rise;
         logic ev_pos_chg;

         assign indep = ctrl_r[g][bsc_pkg::CTRL_INDEP];
         assign en[g] = ctrl_r[g][bsc_pkg::CTRL_FUNC_EN];
         // Inputs read zero while a pole is open, so one means closed.
         assign pa = pos_a_gang[g];
         assign pb = indep ? pos_b[g] : pa;
         assign pc = indep ? pos_c[g] : pa;
         assign pole_closed[3*g +: 3] = {pc, pb, pa};
         assign bkr_closed[g] = indep ? (pa & pb & pc) : pa;
         // Ganged mode copies phase A to all poles, so it can never disagree.
         assign disagree_now[g] = en[g] && indep && poles_differ(pa, pb, pc);
         assign pole_disagree[g] = dis_r[g];
         assign manual_close_hold[g] = mc_r[g];

         // A push button only counts while push-button control is enabled.
         assign pb_ok     = ctrl_r[g][bsc_pkg::CTRL_PB_EN];
         assign open_nxt  = en[g] && (open_cmd[g] || (pb_ok && pb_open[g]));
         assign close_nxt = en[g] && (close_cmd[g] || (pb_ok && pb_close[g]));
         assign dis_due   = dis_cnt_r[g] >= alarm_dly_r[g];
         assign mc_step   = mc_r[g] && tick;
         assign mc_end[g] = mc_step && (mc_cnt_r[g] == 32'h0);

         // Interrupt events of this breaker.
         assign ev_dis_rise   = dis_r[g] && !dis_prev_r[g];
         assign ev_alarm_rise = bkr_alarm[g] && !alarm_prev_r[g];
         assign ev_pos_chg    = en[g] && (bkr_closed[g] != closed_prev_r[g]);
         assign irq_set[4*g + bsc_pkg::IRQ_DISAGREE] = ev_dis_rise;
         assign irq_set[4*g + bsc_pkg::IRQ_ALARM]    = ev_alarm_rise;
         assign irq_set[4*g + bsc_pkg::IRQ_POSCHG]   = ev_pos_chg;
         assign irq_set[4*g + bsc_pkg::IRQ_MCEND]    = mc_end[g];

         // Open and close outputs, gated by the function and push-button settings.
         always_ff @(posedge clk) begin
            if (rst) begin
               bkr_open_out[g]  <= 1'b0;
               bkr_close_out[g] <= 1'b0;
            end else begin
               bkr_open_out[g]  <= open_nxt;
               bkr_close_out[g] <= close_nxt;
            end
         end

         // Indications are gated like the commands, so a disabled breaker reports no alarm, out-of-service or local indication.
         always_ff @(posedge clk) begin
            if (rst) begin
               bkr_alarm[g]          <= 1'b0;
               bkr_out_of_service[g] <= 1'b0;
               bkr_local[g]          <= 1'b0;
            end else begin
               bkr_alarm[g]          <= en[g] && external_breaker_alarm_input[g];
               bkr_out_of_service[g] <= en[g] && breaker_out_of_service_input[g];
               bkr_local[g]          <= en[g] && local_control_status_source[g];
            end
         end

         // Disagreement timer counts 1 ms steps while poles differ.
         // A delay of zero flags the disagreement one cycle after the poles part.
         always_ff @(posedge clk) begin
            if (rst || !disagree_now[g]) begin
               dis_cnt_r[g] <= '0;
               dis_r[g]     <= 1'b0;
            end else if (dis_due) begin
               dis_r[g] <= 1'b1;
            end else if (tick) begin
               dis_cnt_r[g] <= dis_cnt_r[g] + 32'h1;
            end
         end

         // Manual close hold: restarts on each manual close, ends after the interval.
         // A hold interval of zero gives no hold at all.
         always_ff @(posedge clk) begin
            if (rst || !en[g]) begin
               mc_r[g]     <= 1'b0;
               mc_cnt_r[g] <= '0;
            end else if (manual_close[g]) begin
               mc_r[g]     <= (mc_hold_r[g] != 32'h0);
               mc_cnt_r[g] <= mc_hold_r[g] - 32'h1;
            end else if (mc_step) begin
               if (mc_cnt_r[g] == 32'h0) begin
                  mc_r[g] <= 1'b0;
               end else begin
                  mc_cnt_r[g] <= mc_cnt_r[g] - 32'h1;
               end
            end
         end

         // Edge history resets to the idle level of each source, so no false event follows.
         always_ff @(posedge clk) begin
            if (rst) begin
               closed_prev_r[g] <= 1'b0;
               alarm_prev_r[g]  <= 1'b0;
               dis_prev_r[g]    <= 1'b0;
            end else begin
               closed_prev_r[g] <= bkr_closed[g];
               alarm_prev_r[g]  <= bkr_alarm[g];
               dis_prev_r[g]    <= dis_r[g];
            end
         end

         // Control setting of this breaker.
         always_ff @(posedge clk) begin
            if (rst) begin
               ctrl_r[g] <= bsc_pkg::CTRL_RESET;
            end else if (reg_wr && word_hit(reg_addr, bsc_pkg::ADDR_CTRL0, g)) begin
               ctrl_r[g] <= reg_wdata[2:0];
            end
         end

         // Pole disagreement delay in 1 ms steps.
         always_ff @(posedge clk) begin
            if (rst) begin
               alarm_dly_r[g] <= bsc_pkg::DELAY_RESET;
            end else if (reg_wr && word_hit(reg_addr, bsc_pkg::ADDR_ALMDLY0, g)) begin
               alarm_dly_r[g] <= reg_wdata;
            end
         end

         // Manual close hold interval in 1 ms steps.
         always_ff @(posedge clk) begin
            if (rst) begin
               mc_hold_r[g] <= bsc_pkg::DELAY_RESET;
            end else if (reg_wr && word_hit(reg_addr, bsc_pkg::ADDR_MCHOLD0, g)) begin
               mc_hold_r[g] <= reg_wdata;
            end
         end
      end
   endgenerate

   // A read of the status word clears it, but an event in the same cycle still lands.
   assign irq_rd_clr = reg_rd && (reg_addr == bsc_pkg::ADDR_IRQST);

   always_comb begin
      irq_st_nxt = irq_st_r | irq_set;
      if (irq_rd_clr) begin
         irq_st_nxt = irq_set;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_st_r <= '0;
      end else begin
         irq_st_r <= irq_st_nxt;
      end
   end

   // A set mask bit lets the matching status bit raise the interrupt.
   assign msk_wr = reg_wr && (reg_addr == bsc_pkg::ADDR_IRQMSK);

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_msk_r <= '0;
      end else if (msk_wr) begin
         irq_msk_r <= reg_wdata[4*NBKR-1:0];
      end
   end

   // Level interrupt while any unmasked status bit is set.
   assign irq = |(irq_st_r & irq_msk_r);

   // The read word is decoded combinationally and registered below.
   assign rd_word = read_word(reg_addr);

   // Read data stands in the cycle after the read strobe; unmapped reads return zero.
   always_ff @(posedge clk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= rd_word;
      end
   end

endmodule // bsc_breaker_ctrl

// ### bench/bsc_contacts.sv
// Breaker auxiliary contact model: poles follow the relay's open and close outputs.
module bsc_contacts (
   // Clock.
   input  wire logic       clk,
   // Relay outputs and a bench control that holds pole C open.
   input  wire logic [1:0] bkr_open_out,
   input  wire logic [1:0] bkr_close_out,
   input  wire logic [1:0] jam_c,
   // Pole position contacts.
   output logic      [1:0] pos_a_gang,
   output logic      [1:0] pos_b,
   output logic      [1:0] pos_c
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] shut_r = 2'h0;
   // Open wins over close, as a trip coil overrides a close coil.
   always_ff @(posedge clk) begin
      shut_r <= (shut_r | bkr_close_out) & ~bkr_open_out;
   end
   assign pos_a_gang = shut_r;
   assign pos_b      = shut_r;
   assign pos_c      = shut_r & ~jam_c;
endmodule // bsc_contacts

// ### bench/bsc_chk.sv
// Port-level checker for the breaker control block.
module bsc_chk #(
   parameter int NBKR = 2
) (
   input wire logic               clk, rst, reg_wr,
   input wire logic [3:0]         reg_addr,
   input wire logic [31:0]        reg_wdata,
   input wire logic [NBKR-1:0]    open_cmd, close_cmd, pos_a_gang, pos_b, pos_c,
   input wire logic [NBKR-1:0]    external_breaker_alarm_input, bkr_open_out, bkr_close_out,
   input wire logic [NBKR-1:0]    bkr_closed, pole_disagree, bkr_alarm, manual_close_hold,
   input wire logic [3*NBKR-1:0]  pole_closed,
   input wire logic               irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] c0_r;
   // Shadow of the first breaker's enable, push-button enable and independent mode.
   always_ff @(posedge clk) begin
      if (rst) begin
         c0_r <= bsc_pkg::CTRL_RESET;
      end else if (reg_wr && reg_addr == bsc_pkg::ADDR_CTRL0) begin
         c0_r <= reg_wdata[2:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_OFF_QUIET:
      assert property (!c0_r[0] |=> !bkr_open_out[0] && !bkr_close_out[0] && !bkr_alarm[0])
      else $error("disabled breaker drove an output");
   AST_PB_GATE:
      assert property (c0_r[0] && !c0_r[1] && !open_cmd[0] |=> !bkr_open_out[0])
      else $error("push button acted while not allowed");
   AST_GANG_POS:
      assert property (!c0_r[2] |-> pole_closed[2:0] == {3{pos_a_gang[0]}}
         && bkr_closed[0] == pos_a_gang[0]) else $error("ganged position wrong");
   AST_INDEP_POS:
      assert property (c0_r[2] |-> pole_closed[2:0] == {pos_c[0], pos_b[0], pos_a_gang[0]}
         && bkr_closed[0] == &pole_closed[2:0]) else $error("pole position wrong");
   AST_GANG_NO_DIS:
      assert property (!c0_r[2] |=> !pole_disagree[0])
      else $error("disagreement flagged in ganged mode");
   AST_OPEN_FOLLOW:
      assert property (c0_r[0] && open_cmd[0] |=> bkr_open_out[0])
      else $error("open output missed");
   AST_CLOSE_FOLLOW:
      assert property (c0_r[0] && close_cmd[0] |=> bkr_close_out[0])
      else $error("close output missed");
   AST_ALARM_PASS:
      assert property (c0_r[0] |=> bkr_alarm[0] == $past(external_breaker_alarm_input[0]))
      else $error("alarm indication wrong");
   AST_AGREE_CLEAR:
      assert property (pos_a_gang[0] == pos_b[0] && pos_b[0] == pos_c[0] |=> !pole_disagree[0])
      else $error("disagreement held while poles agree");
   cover property (c0_r[2] ##1 $rose(pole_disagree[0]));
   cover property ($rose(manual_close_hold[0]));
   cover property ($rose(irq));
endmodule // bsc_chk

// ### bench/tb_top.sv
// Testbench for the breaker control block with its contact model.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, reg_wr, reg_rd, irq;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [1:0]  open_cmd, close_cmd, pb_open, pb_close, manual_close, jam_c;
   logic [1:0]  external_breaker_alarm_input, breaker_out_of_service_input;
   logic [1:0]  local_control_status_source, pos_a_gang, pos_b, pos_c;
   logic [1:0]  bkr_open_out, bkr_close_out, bkr_closed, pole_disagree, bkr_alarm;
   logic [1:0]  bkr_out_of_service, bkr_local, manual_close_hold;
   logic [5:0]  pole_closed;
   int          miscompares = 0;
   int          n_tests = 0;
   int          n;
   bsc_breaker_ctrl #(.NBKR(2)) bsc_breaker_ctrl_inst (.*);
   bsc_contacts bsc_contacts_inst (.*);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop();
      if (miscompares == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // The longest waits are two disagreement ticks and one hold interval.
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 36'h0};
      {open_cmd, close_cmd, pb_open, pb_close, manual_close, jam_c} = 12'h0;
      {external_breaker_alarm_input, breaker_out_of_service_input} = 4'h0;
      local_control_status_source = 2'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(bsc_pkg::ADDR_CTRL0, 32'h0);
      wr(4'ha, 32'hffffffff);
      rd(4'ha, 32'h0);
      @(posedge clk);
      open_cmd <= 2'h3;
      close_cmd <= 2'h3;
      wt(2);
      chk(bkr_open_out | bkr_close_out, 2'h0);
      @(posedge clk);
      open_cmd <= 2'h0;
      close_cmd <= 2'h0;
      wr(bsc_pkg::ADDR_CTRL0, 32'h1);
      rd(bsc_pkg::ADDR_IRQST, 32'h0);
      @(posedge clk);
      external_breaker_alarm_input <= 2'h3;
      breaker_out_of_service_input <= 2'h3;
      local_control_status_source <= 2'h3;
      wt(3);
      chk({bkr_alarm, bkr_out_of_service, bkr_local}, 6'h15);
      chk(irq, 1'b0);
      wr(bsc_pkg::ADDR_IRQMSK, 32'h2);
      wt(1);
      chk(irq, 1'b1);
      rd(bsc_pkg::ADDR_IRQST, 32'h2);
      wt(1);
      chk(irq, 1'b0);
      @(posedge clk);
      pb_open <= 2'h1;
      wt(2);
      chk(bkr_open_out, 2'h0);
      wr(bsc_pkg::ADDR_CTRL0, 32'h3);
      wt(2);
      chk(bkr_open_out, 2'h1);
      @(posedge clk);
      pb_open <= 2'h0;
      jam_c <= 2'h1;
      close_cmd <= 2'h1;
      wt(3);
      chk({bkr_close_out[0], bkr_closed[0], pole_closed[2:0]}, 5'h1f);
      @(posedge clk);
      close_cmd <= 2'h0;
      wr(bsc_pkg::ADDR_ALMDLY0, 32'h2);
      wr(bsc_pkg::ADDR_CTRL0, 32'h7);
      wt(1);
      chk({bkr_closed[0], pole_closed[2:0]}, 4'h3);
      n = 0;
      while (pole_disagree[0] !== 1'b1 && n < 80000) begin
         wt(1);
         n++;
      end
      chk(n > 25000 && pole_disagree[0] === 1'b1, 1'b1);
      @(posedge clk);
      jam_c <= 2'h0;
      wt(2);
      chk(pole_disagree[0], 1'b0);
      wr(bsc_pkg::ADDR_MCHOLD0, 32'h1);
      rd(bsc_pkg::ADDR_ALMDLY1, 32'h0);
      rd(bsc_pkg::ADDR_MCHOLD0, 32'h1);
      @(posedge clk);
      manual_close <= 2'h1;
      @(posedge clk);
      manual_close <= 2'h0;
      wt(0);
      chk(manual_close_hold[0], 1'b1);
      n = 0;
      while (manual_close_hold[0] !== 1'b0 && n < 30000) begin
         wt(1);
         n++;
      end
      chk(n <= 25002 && manual_close_hold[0] === 1'b0, 1'b1);
      wr(bsc_pkg::ADDR_CTRL1, 32'h1);
      @(posedge clk);
      open_cmd <= 2'h2;
      wt(2);
      chk(bkr_open_out, 2'h2);
      rd(bsc_pkg::ADDR_STATUS0, 32'hef);
      rd(bsc_pkg::ADDR_STATUS1, 32'h2e0);
      report_and_stop();
   end
endmodule // tb_top
bind bsc_breaker_ctrl bsc_chk #(.NBKR(NBKR)) bsc_chk_inst (.*);
